// ==== rtl/scl_top.sv ====
/*
  scl_top: two-channel scramble, power-down and signal-loss control with a
  management register port.
  assumes all inputs are synchronous to mclk and that the pad ring resolves
  the output enables into high-impedance pins.
*/
`timescale 1ns/1ps
`default_nettype none
module scl_top
  import scl_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic chan_a_powerdown_n,
  input wire logic chan_b_powerdown_n,
  input wire logic [WORD_W-1:0] chan_a_tx_word,
  input wire logic [WORD_W-1:0] chan_b_tx_word,
  output logic [WORD_W-1:0] chan_a_ser_word,
  output logic [WORD_W-1:0] chan_b_ser_word,
  output logic chan_a_ser_oe,
  output logic chan_b_ser_oe,
  input wire logic [WORD_W-1:0] chan_a_rx_dec_word,
  input wire logic [WORD_W-1:0] chan_b_rx_dec_word,
  output logic [WORD_W-1:0] chan_a_rx_word,
  output logic [WORD_W-1:0] chan_b_rx_word,
  output logic chan_a_rx_oe,
  output logic chan_b_rx_oe,
  output logic [8:0] chan_a_deemph,
  output logic [8:0] chan_b_deemph,
  output logic chan_a_signal_loss,
  output logic chan_b_signal_loss,
  input wire logic general_input_one,
  input wire logic [NUM_CHAN-1:0] los_detect,
  input wire logic [NUM_CHAN-1:0] sync_lost,
  input wire logic [NUM_CHAN-1:0] pll_unlock,
  input wire logic [NUM_CHAN-1:0] rate_sense_locked,
  input wire logic [NUM_CHAN-1:0] gain_control_locked,
  input wire logic [NUM_CHAN-1:0] offset_cal_done
);
  logic rst_meta_reg;
  logic rst_n;
  logic [NUM_CHAN-1:0][WORD_W-1:0] tx_in;
  logic [NUM_CHAN-1:0][WORD_W-1:0] rx_in;
  logic [NUM_CHAN-1:0][WORD_W-1:0] ser_q;
  logic [NUM_CHAN-1:0][WORD_W-1:0] rx_q;
  logic [NUM_CHAN-1:0] pd_pin;
  logic [NUM_CHAN-1:0] pd;
  logic [NUM_CHAN-1:0] oe_reg;
  logic [NUM_CHAN-1:0] loss_now;
  logic [NUM_CHAN-1:0] loss_reg;
  logic [NUM_CHAN-1:0][DATA_W-1:0] ctrl_reg;
  logic [NUM_CHAN-1:0][DATA_W-1:0] deemph_reg;
  logic [NUM_CHAN-1:0][DATA_W-1:0] cfg3_reg;
  logic [NUM_CHAN-1:0][DATA_W-1:0] losen_reg;
  logic [NUM_CHAN-1:0][DATA_W-1:0] rxen_reg;
  logic [NUM_CHAN-1:0][DATA_W-1:0] rate_reg;
  logic [NUM_CHAN-1:0][DATA_W-1:0] scr_reg;
  logic [NUM_CHAN-1:0][DATA_W-1:0] txseed_reg;
  logic [NUM_CHAN-1:0][DATA_W-1:0] rxseed_reg;
  logic [DATA_W-1:0] rdata_next;
  logic rd_ch;

  // the second stage alone feeds the design
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  assign tx_in = {chan_b_tx_word, chan_a_tx_word};
  assign rx_in = {chan_b_rx_dec_word, chan_a_rx_dec_word};
  assign pd_pin = {!chan_b_powerdown_n, !chan_a_powerdown_n};

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      logic wsel;
      assign wsel = reg_wr && (reg_addr[5] == 1'(ch));

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          ctrl_reg[ch] <= REG_RESET;
          deemph_reg[ch] <= REG_RESET;
          cfg3_reg[ch] <= REG_RESET;
          losen_reg[ch] <= REG_RESET;
          rxen_reg[ch] <= REG_RESET;
          rate_reg[ch] <= REG_RESET;
          scr_reg[ch] <= REG_RESET;
          txseed_reg[ch] <= {9'h000, SEED_RESET};
          rxseed_reg[ch] <= {9'h000, SEED_RESET};
        end else if (wsel) begin
          unique case (reg_addr[4:0])
            REG_CTRL: ctrl_reg[ch] <= reg_wdata & CTRL_MASK;
            REG_DEEMPH: deemph_reg[ch] <= reg_wdata & DEEMPH_MASK;
            REG_CFG3: cfg3_reg[ch] <= reg_wdata & CFG3_MASK;
            REG_LOSEN: losen_reg[ch] <= reg_wdata & LOSEN_MASK;
            REG_RXEN: rxen_reg[ch] <= reg_wdata & RXEN_MASK;
            REG_RATE: rate_reg[ch] <= reg_wdata & RATE_MASK;
            REG_SCR: scr_reg[ch] <= reg_wdata & SCR_MASK;
            REG_TXSEED: txseed_reg[ch] <= reg_wdata & SEED_MASK;
            REG_RXSEED: rxseed_reg[ch] <= reg_wdata & SEED_MASK;
            default: ;
          endcase
        end
      end

      assign pd[ch] = pd_pin[ch] || ctrl_reg[ch][PD_BIT];

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          oe_reg[ch] <= 1'b0;
        end else begin
          oe_reg[ch] <= !pd[ch];
        end
      end

      scl_lane u_tx (
        .clk(mclk),
        .rst_n(rst_n),
        .run(!pd[ch]),
        .scr_en(scr_reg[ch][SCR_EN_BIT]),
        .raw20(scr_reg[ch][RAW20_BIT]),
        .seed(txseed_reg[ch][LFSR_W-1:0]),
        .word_in(tx_in[ch]),
        .word_out(ser_q[ch])
      );

      // no seed exchange exists, so the receive seed is trusted as programmed
      scl_lane u_rx (
        .clk(mclk),
        .rst_n(rst_n),
        .run(!pd[ch]),
        .scr_en(scr_reg[ch][SCR_EN_BIT]),
        .raw20(scr_reg[ch][RAW20_BIT]),
        .seed(rxseed_reg[ch][LFSR_W-1:0]),
        .word_in(rx_in[ch]),
        .word_out(rx_q[ch])
      );

      scl_los u_los (
        .en_los(losen_reg[ch][EN_LOS_BIT]),
        .en_gpi(losen_reg[ch][EN_GPI_BIT]),
        .en_sync(losen_reg[ch][EN_SYNC_BIT]),
        .en_pll(losen_reg[ch][EN_PLL_BIT]),
        .en_dec(losen_reg[ch][EN_DEC_BIT]),
        .en_ars(rate_reg[ch][EN_ARS_BIT]),
        .en_agc(rxen_reg[ch][EN_AGC_BIT]),
        .en_az(rxen_reg[ch][EN_AZ_BIT]),
        .raw20(scr_reg[ch][RAW20_BIT]),
        .comma_en(cfg3_reg[ch][COMMA_EN_BIT]),
        .los_detect(los_detect[ch]),
        .gpi(general_input_one),
        .sync_lost(sync_lost[ch]),
        .pll_unlock(pll_unlock[ch]),
        .dec_err(!scr_reg[ch][RAW20_BIT] && (rx_in[ch][19] || rx_in[ch][9])),
        .rate_locked(rate_sense_locked[ch]),
        .agc_locked(gain_control_locked[ch]),
        .az_done(offset_cal_done[ch]),
        .loss(loss_now[ch])
      );

      // one register stage keeps the pin glitch free
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          loss_reg[ch] <= 1'b0;
        end else begin
          loss_reg[ch] <= loss_now[ch];
        end
      end
    end
  endgenerate

  // register reads ignore power-down so software can always reach the port
  assign rd_ch = reg_addr[5];
  always_comb begin
    rdata_next = '0;
    unique case (reg_addr[4:0])
      REG_CTRL: rdata_next = ctrl_reg[rd_ch];
      REG_DEEMPH: rdata_next = deemph_reg[rd_ch];
      REG_CFG3: rdata_next = cfg3_reg[rd_ch];
      REG_STAT: rdata_next[LOS_STAT_BIT] = loss_reg[rd_ch];
      REG_LOSEN: rdata_next = losen_reg[rd_ch];
      REG_RXEN: rdata_next = rxen_reg[rd_ch];
      REG_RATE: rdata_next = rate_reg[rd_ch];
      REG_SCR: rdata_next = scr_reg[rd_ch];
      REG_TXSEED: rdata_next = txseed_reg[rd_ch];
      REG_RXSEED: rdata_next = rxseed_reg[rd_ch];
      default: rdata_next = '0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= '0;
    end
  end

  assign chan_a_ser_word = ser_q[0];
  assign chan_b_ser_word = ser_q[1];
  assign chan_a_rx_word = rx_q[0];
  assign chan_b_rx_word = rx_q[1];
  assign chan_a_ser_oe = oe_reg[0];
  assign chan_b_ser_oe = oe_reg[1];
  assign chan_a_rx_oe = oe_reg[0];
  assign chan_b_rx_oe = oe_reg[1];
  assign chan_a_deemph = deemph_reg[0][DEEMPH_MSB:DEEMPH_LSB];
  assign chan_b_deemph = deemph_reg[1][DEEMPH_MSB:DEEMPH_LSB];
  assign chan_a_signal_loss = loss_reg[0];
  assign chan_b_signal_loss = loss_reg[1];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_pd_write;
    reg_wr && reg_addr == {1'b0, REG_CTRL} && reg_wdata[PD_BIT];
  endsequence
  sequence s_pd_applied;
    ##2 !chan_a_rx_oe && !chan_a_ser_oe;
  endsequence

  property p_pd_reg;
    s_pd_write |-> s_pd_applied;
  endproperty
  a_pd_reg: assert property (p_pd_reg) else $error("register power-down did not release outputs");

  property p_pd_pin;
    !chan_a_powerdown_n |=> !chan_a_rx_oe;
  endproperty
  a_pd_pin: assert property (p_pd_pin) else $error("pin power-down did not release outputs");

  property p_los_raw;
    los_detect[0] && losen_reg[0][EN_LOS_BIT] |=> chan_a_signal_loss;
  endproperty
  a_los_raw: assert property (p_los_raw) else $error("raw loss not reported");

  property p_los_quiet;
    (losen_reg[0] == '0 && rxen_reg[0] == '0 && rate_reg[0] == '0) |=> !chan_a_signal_loss;
  endproperty
  a_los_quiet: assert property (p_los_quiet) else $error("signal loss with no condition enabled");

  property p_gpi;
    losen_reg[1][EN_GPI_BIT] && !general_input_one |=> chan_b_signal_loss;
  endproperty
  a_gpi: assert property (p_gpi) else $error("general input not merged");

  property p_pll;
    losen_reg[0][EN_PLL_BIT] && pll_unlock[0] |=> chan_a_signal_loss;
  endproperty
  a_pll: assert property (p_pll) else $error("pll unlock not merged");

  property p_stat;
    reg_rd && reg_addr == {1'b0, REG_STAT} |=> reg_rdata[LOS_STAT_BIT] == $past(chan_a_signal_loss);
  endproperty
  a_stat: assert property (p_stat) else $error("status bit does not show signal loss");

  property p_ctrl_pass;
    chan_a_tx_word[18] && !scr_reg[0][RAW20_BIT] && !pd[0] |=> chan_a_ser_word[18:10] == $past(chan_a_tx_word[18:10]);
  endproperty
  a_ctrl_pass: assert property (p_ctrl_pass) else $error("control character altered");

  property p_deemph;
    reg_wr && reg_addr == {1'b0, REG_DEEMPH} |=> chan_a_deemph == $past(reg_wdata[DEEMPH_MSB:DEEMPH_LSB]);
  endproperty
  a_deemph: assert property (p_deemph) else $error("de-emphasis field not applied");
endmodule : scl_top
`default_nettype wire

// ==== rtl/scl_pkg.sv ====
/*
  scl_pkg: register numbers, field positions, reset values and codes shared by
  the scramble / power-down / signal-loss channel logic.
  assumes a management port whose address carries a channel bit above a
  five-bit register number, with 16-bit register data.
*/
package scl_pkg;
  localparam int NUM_CHAN = 2;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int WORD_W = 20;
  localparam int LFSR_W = 7;

  localparam logic [4:0] REG_CTRL = 5'h01;
  localparam logic [4:0] REG_DEEMPH = 5'h02;
  localparam logic [4:0] REG_CFG3 = 5'h03;
  localparam logic [4:0] REG_STAT = 5'h05;
  localparam logic [4:0] REG_LOSEN = 5'h06;
  localparam logic [4:0] REG_RXEN = 5'h07;
  localparam logic [4:0] REG_RATE = 5'h0A;
  localparam logic [4:0] REG_SCR = 5'h14;
  localparam logic [4:0] REG_TXSEED = 5'h15;
  localparam logic [4:0] REG_RXSEED = 5'h16;

  localparam int PD_BIT = 15;
  localparam int DEEMPH_LSB = 4;
  localparam int DEEMPH_MSB = 12;
  localparam int COMMA_EN_BIT = 7;
  localparam int LOS_STAT_BIT = 2;
  localparam int EN_GPI_BIT = 11;
  localparam int EN_LOS_BIT = 10;
  localparam int EN_SYNC_BIT = 9;
  localparam int EN_PLL_BIT = 8;
  localparam int EN_DEC_BIT = 3;
  localparam int EN_AGC_BIT = 7;
  localparam int EN_AZ_BIT = 6;
  localparam int EN_ARS_BIT = 14;
  localparam int SCR_EN_BIT = 0;
  localparam int RAW20_BIT = 1;

  localparam logic [15:0] CTRL_MASK = 16'h8000;
  localparam logic [15:0] DEEMPH_MASK = 16'h1FF0;
  localparam logic [15:0] CFG3_MASK = 16'h0080;
  localparam logic [15:0] LOSEN_MASK = 16'h0F08;
  localparam logic [15:0] RXEN_MASK = 16'h00C0;
  localparam logic [15:0] RATE_MASK = 16'h4000;
  localparam logic [15:0] SCR_MASK = 16'h0003;
  localparam logic [15:0] SEED_MASK = 16'h007F;

  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [6:0] SEED_RESET = 7'h7F;

  localparam logic [7:0] K28_1_BYTE = 8'h3C;
  localparam logic [7:0] K28_5_BYTE = 8'hBC;
  localparam logic [7:0] K28_7_BYTE = 8'hFC;
endpackage : scl_pkg

// ==== rtl/scl_lane.sv ====
/*
  scl_lane: one scrambler or descrambler stage for a two-symbol parallel word,
  registered output. additive scrambling makes the same logic its own inverse.
  assumes the first symbol sits in bits 18:10 and the second in 8:0.
*/
`timescale 1ns/1ps
`default_nettype none
module scl_lane
  import scl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic scr_en,
  input wire logic raw20,
  input wire logic [LFSR_W-1:0] seed,
  input wire logic [WORD_W-1:0] word_in,
  output logic [WORD_W-1:0] word_out
);
  logic [LFSR_W-1:0] lfsr_reg;
  logic [LFSR_W-1:0] lfsr_mid;
  logic [LFSR_W-1:0] lfsr_next;
  logic [8:0] sym0_out;
  logic [8:0] sym1_out;

  // returns {next state, symbol}; k characters bypass; K28.1, K28.5 and K28.7 load the seed, other k characters hold the state
  function automatic logic [15:0] scr_sym(input logic [6:0] st, input logic [8:0] sym, input logic [6:0] sd);
    logic [6:0] s;
    logic [8:0] o;
    logic fb;
    s = st;
    o = sym;
    if (sym[8]) begin
      if (sym[7:0] == K28_1_BYTE || sym[7:0] == K28_5_BYTE || sym[7:0] == K28_7_BYTE) begin
        s = sd;
      end
    end else begin
      for (int i = 7; i >= 0; i--) begin
        fb = s[6] ^ s[5];
        o[i] = sym[i] ^ fb;
        s = {s[5:0], fb};
      end
    end
    return {s, o};
  endfunction : scr_sym

  always_comb begin
    {lfsr_mid, sym0_out} = scr_sym(lfsr_reg, word_in[18:10], seed);
    {lfsr_next, sym1_out} = scr_sym(lfsr_mid, word_in[8:0], seed);
  end

  // run drops in power-down, so the sequence freezes rather than drifting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_reg <= SEED_RESET;
    end else if (run && scr_en && !raw20) begin
      lfsr_reg <= lfsr_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_out <= '0;
    end else if (run) begin
      if (raw20) begin
        word_out <= word_in;
      end else if (scr_en) begin
        word_out <= {word_in[19], sym0_out, word_in[9], sym1_out};
      end else begin
        word_out <= word_in;
      end
    end
  end
endmodule : scl_lane
`default_nettype wire

// ==== rtl/scl_los.sv ====
/*
  scl_los: combinational signal-loss aggregation for one channel.
  assumes enables come from management registers and conditions are synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module scl_los
  import scl_pkg::*;
(
  input wire logic en_los,
  input wire logic en_gpi,
  input wire logic en_sync,
  input wire logic en_pll,
  input wire logic en_dec,
  input wire logic en_ars,
  input wire logic en_agc,
  input wire logic en_az,
  input wire logic raw20,
  input wire logic comma_en,
  input wire logic los_detect,
  input wire logic gpi,
  input wire logic sync_lost,
  input wire logic pll_unlock,
  input wire logic dec_err,
  input wire logic rate_locked,
  input wire logic agc_locked,
  input wire logic az_done,
  output logic loss
);
  logic sync_term;

  // in raw mode sync means nothing without comma detection
  assign sync_term = en_sync && sync_lost && (!raw20 || comma_en);
  assign loss = (en_los && los_detect)
    || (en_gpi && !gpi)
    || sync_term
    || (en_pll && pll_unlock)
    || (en_dec && dec_err)
    || (en_ars && !rate_locked)
    || (en_agc && !agc_locked)
    || (en_az && !az_done);
endmodule : scl_los
`default_nettype wire

// ==== bench/scl_far_end.sv ====
/*
  scl_far_end: remote transceiver model facing channel a. scrambles the words
  it sends and descrambles the words it receives, one word per clock.
  assumes every stream opens with a seed-loading comma, so no reset is needed.
*/
`timescale 1ns/1ps
`default_nettype none
module scl_far_end
  import scl_pkg::*;
(
  input wire logic mclk,
  input wire logic scr_on,
  input wire logic dec_err,
  input wire logic [LFSR_W-1:0] tx_seed,
  input wire logic [LFSR_W-1:0] rx_seed,
  input wire logic [WORD_W-1:0] plain_out,
  output logic [WORD_W-1:0] line_out,
  input wire logic [WORD_W-1:0] line_in,
  output logic [WORD_W-1:0] plain_in
);
  logic [LFSR_W-1:0] out_reg, in_reg, out_next, in_next;
  logic [WORD_W-1:0] enc_w, dec_w;

  // additive code: the same walk scrambles and descrambles
  function automatic logic [15:0] code_sym(input logic [8:0] sym, input logic [6:0] s, input logic [6:0] seed);
    logic fb;
    if (sym[8]) begin
      if (sym[7:0] == K28_1_BYTE || sym[7:0] == K28_5_BYTE || sym[7:0] == K28_7_BYTE) begin
        s = seed;
      end
      return {s, sym};
    end
    for (int i = 7; i >= 0; i--) begin
      fb = s[6] ^ s[5];
      sym[i] = sym[i] ^ fb;
      s = {s[5:0], fb};
    end
    return {s, sym};
  endfunction : code_sym

  function automatic logic [26:0] code_word(input logic [19:0] w, input logic [6:0] s, input logic [6:0] seed);
    logic [15:0] a;
    logic [15:0] b;
    a = code_sym(w[18:10], s, seed);
    b = code_sym(w[8:0], a[15:9], seed);
    return {b[15:9], w[19], a[8:0], w[9], b[8:0]};
  endfunction : code_word

  always_comb begin
    {out_next, enc_w} = code_word(plain_out, out_reg, rx_seed);
    {in_next, dec_w} = code_word(line_in, in_reg, tx_seed);
    if (!scr_on) begin
      out_next = out_reg;
      in_next = in_reg;
      enc_w = plain_out;
      dec_w = line_in;
    end
    line_out = enc_w | {dec_err, 19'h0};
    plain_in = dec_w;
  end

  always_ff @(posedge mclk) begin
    out_reg <= out_next;
    in_reg <= in_next;
  end
endmodule : scl_far_end
`default_nettype wire

// ==== bench/serdes_channel_scramble_los_test.sv ====
/*
  serdes_channel_scramble_los_test: self-checking bench for scl_top with the
  remote transceiver model on channel a.
  assumes the register port answers reads in the following cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHECK(name, exp, got) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] %s expected %0h seen %0h", name, exp, got); end end
module serdes_channel_scramble_los_test
  import scl_pkg::*;
;
  localparam logic [WORD_W-1:0] COMMA = {1'h0, 9'h1BC, 1'h0, 9'h1BC};
  localparam logic [6:0] TXS = 7'h2A;
  localparam logic [6:0] RXS = 7'h55;
  localparam logic [4:0] COND_REG [8] = '{REG_LOSEN, REG_LOSEN, REG_LOSEN, REG_LOSEN, REG_LOSEN,
    REG_RATE, REG_RXEN, REG_RXEN};
  localparam int COND_BIT [8] = '{EN_LOS_BIT, EN_GPI_BIT, EN_SYNC_BIT, EN_PLL_BIT, EN_DEC_BIT,
    EN_ARS_BIT, EN_AGC_BIT, EN_AZ_BIT};
  int mismatches = 0;
  int tests_run = 0;
  logic mclk = 1'h0, rstn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, far_on = 1'h0, far_err = 1'h0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
  logic chan_a_powerdown_n = 1'h1, chan_b_powerdown_n = 1'h1, general_input_one = 1'h1;
  logic [WORD_W-1:0] chan_a_tx_word = COMMA, chan_b_tx_word = COMMA, chan_b_rx_dec_word = COMMA;
  logic [WORD_W-1:0] far_src = COMMA, chan_a_rx_dec_word, far_plain;
  logic [WORD_W-1:0] chan_a_ser_word, chan_b_ser_word, chan_a_rx_word, chan_b_rx_word;
  logic chan_a_ser_oe, chan_b_ser_oe, chan_a_rx_oe, chan_b_rx_oe, chan_a_signal_loss, chan_b_signal_loss;
  logic [8:0] chan_a_deemph, chan_b_deemph;
  logic [NUM_CHAN-1:0] los_detect = '0, sync_lost = '0, pll_unlock = '0;
  logic [NUM_CHAN-1:0] rate_sense_locked = '1, gain_control_locked = '1, offset_cal_done = '1;

  scl_top dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_a_powerdown_n(chan_a_powerdown_n),
    .chan_b_powerdown_n(chan_b_powerdown_n), .chan_a_tx_word(chan_a_tx_word), .chan_b_tx_word(chan_b_tx_word),
    .chan_a_ser_word(chan_a_ser_word), .chan_b_ser_word(chan_b_ser_word), .chan_a_ser_oe(chan_a_ser_oe),
    .chan_b_ser_oe(chan_b_ser_oe), .chan_a_rx_dec_word(chan_a_rx_dec_word),
    .chan_b_rx_dec_word(chan_b_rx_dec_word), .chan_a_rx_word(chan_a_rx_word), .chan_b_rx_word(chan_b_rx_word),
    .chan_a_rx_oe(chan_a_rx_oe), .chan_b_rx_oe(chan_b_rx_oe), .chan_a_deemph(chan_a_deemph),
    .chan_b_deemph(chan_b_deemph), .chan_a_signal_loss(chan_a_signal_loss),
    .chan_b_signal_loss(chan_b_signal_loss), .general_input_one(general_input_one), .los_detect(los_detect),
    .sync_lost(sync_lost), .pll_unlock(pll_unlock), .rate_sense_locked(rate_sense_locked),
    .gain_control_locked(gain_control_locked), .offset_cal_done(offset_cal_done));

  scl_far_end far (.mclk(mclk), .scr_on(far_on), .dec_err(far_err), .tx_seed(TXS), .rx_seed(RXS),
    .plain_out(far_src), .line_out(chan_a_rx_dec_word), .line_in(chan_a_ser_word), .plain_in(far_plain));

  always #4 mclk = ~mclk;

  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask : reg_write

  task automatic check_reg(input string name, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] d;
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata;
    `CHECK(name, exp, d)
  endtask : check_reg

  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle

  task automatic t_regs;
    #1;
    `CHECK("loss_after_reset", 1'h0, chan_a_signal_loss)
    check_reg("losen_reset", {1'h0, REG_LOSEN}, 16'h0000);
    check_reg("txseed_reset", {1'h0, REG_TXSEED}, {9'h0, SEED_RESET});
    reg_write({1'h0, REG_LOSEN}, 16'hFFFF);
    check_reg("losen_mask", {1'h0, REG_LOSEN}, LOSEN_MASK);
    reg_write({1'h0, REG_LOSEN}, 16'h0000);
    reg_write({1'h0, REG_DEEMPH}, 16'h0A50);
    #1;
    `CHECK("deemph_a", 9'h0A5, chan_a_deemph)
    `CHECK("deemph_b", 9'h000, chan_b_deemph)
    reg_write({1'h1, REG_TXSEED}, 16'h0033);
    check_reg("txseed_b", {1'h1, REG_TXSEED}, 16'h0033);
    check_reg("txseed_a_kept", {1'h0, REG_TXSEED}, {9'h0, SEED_RESET});
    reg_write({1'h0, 5'h1F}, 16'hFFFF);
    check_reg("unmapped", {1'h0, 5'h1F}, 16'h0000);
    $display("test regs done");
  endtask : t_regs

  task automatic set_cond(input int j, input logic bad);
    @(posedge mclk);
    case (j)
      0: los_detect[0] <= bad;
      1: general_input_one <= !bad;
      2: sync_lost[0] <= bad;
      3: pll_unlock[0] <= bad;
      4: far_err <= bad;
      5: rate_sense_locked[0] <= !bad;
      6: gain_control_locked[0] <= !bad;
      default: offset_cal_done[0] <= !bad;
    endcase
  endtask : set_cond

  task automatic t_loss;
    for (int j = 0; j < 8; j++) begin
      set_cond(j, 1'h1);
      settle();
      `CHECK("loss_masked", 1'h0, chan_a_signal_loss)
      reg_write({1'h0, COND_REG[j]}, 16'h0001 << COND_BIT[j]);
      settle();
      `CHECK("loss_enabled", 1'h1, chan_a_signal_loss)
      `CHECK("loss_other_chan", 1'h0, chan_b_signal_loss)
      check_reg("loss_status", {1'h0, REG_STAT}, 16'h0001 << LOS_STAT_BIT);
      set_cond(j, 1'h0);
      settle();
      `CHECK("loss_cleared", 1'h0, chan_a_signal_loss)
      reg_write({1'h0, COND_REG[j]}, 16'h0000);
    end
    // raw mode: sync loss counts only with comma detection on
    reg_write({1'h0, REG_SCR}, 16'h0002);
    reg_write({1'h0, REG_LOSEN}, 16'h0001 << EN_SYNC_BIT);
    sync_lost[0] <= 1'h1;
    settle();
    `CHECK("sync_raw_no_comma", 1'h0, chan_a_signal_loss)
    reg_write({1'h0, REG_CFG3}, CFG3_MASK);
    settle();
    `CHECK("sync_raw_comma", 1'h1, chan_a_signal_loss)
    @(posedge mclk);
    sync_lost[0] <= 1'h0;
    reg_write({1'h0, REG_SCR}, 16'h0000);
    reg_write({1'h0, REG_LOSEN}, LOSEN_MASK);
    reg_write({1'h0, REG_RXEN}, RXEN_MASK);
    reg_write({1'h0, REG_RATE}, RATE_MASK);
    settle();
    `CHECK("all_enabled_good", 1'h0, chan_a_signal_loss)
    @(posedge mclk);
    pll_unlock[0] <= 1'h1;
    settle();
    `CHECK("all_enabled_one_bad", 1'h1, chan_a_signal_loss)
    @(posedge mclk);
    pll_unlock[0] <= 1'h0;
    // channel b has its own enable for the shared general input
    reg_write({1'h1, REG_LOSEN}, 16'h0001 << EN_GPI_BIT);
    general_input_one <= 1'h0;
    settle();
    `CHECK("gpi_chan_b", 1'h1, chan_b_signal_loss)
    @(posedge mclk);
    general_input_one <= 1'h1;
    reg_write({1'h1, REG_LOSEN}, 16'h0000);
    settle();
    `CHECK("gpi_chan_b_clear", 1'h0, chan_b_signal_loss)
    $display("test loss done");
  endtask : t_loss

  task automatic t_scramble;
    logic [WORD_W-1:0] w, prev;
    reg_write({1'h0, REG_TXSEED}, {9'h0, TXS});
    reg_write({1'h0, REG_RXSEED}, {9'h0, RXS});
    reg_write({1'h0, REG_SCR}, 16'h0001);
    far_on <= 1'h1;
    for (int i = 0; i < 48; i++) begin
      w = {2'h0, i[7:0] * 8'h3B + 8'h11, 2'h0, i[7:0] * 8'h5D + 8'h07};
      if (i % 12 == 5) w[18:10] = 9'h1FC;
      if (i % 12 == 7) w[8:0] = 9'h13C;
      if (i % 12 == 9) w[8:0] = 9'h11C;
      @(posedge mclk);
      chan_a_tx_word <= w;
      far_src <= w;
      chan_b_tx_word <= w;
      chan_b_rx_dec_word <= w;
      #1;
      if (i > 0) begin
        `CHECK("tx_descrambled", prev, far_plain)
        `CHECK("rx_descrambled", prev, chan_a_rx_word)
        `CHECK("b_scr_off", prev, chan_b_ser_word)
        `CHECK("b_rx_off", prev, chan_b_rx_word)
        // the sequence never holds eight zero bits, so every data byte must change
        `CHECK("tx_scrambled", 1'h1, chan_a_ser_word != prev)
      end
      prev = w;
    end
    @(posedge mclk);
    chan_a_tx_word <= COMMA;
    far_src <= COMMA;
    reg_write({1'h0, REG_SCR}, 16'h0000);
    far_on <= 1'h0;
    $display("test scramble done");
  endtask : t_scramble

  task automatic t_powerdown;
    logic [WORD_W-1:0] held;
    chan_a_powerdown_n <= 1'h0;
    settle();
    held = chan_a_ser_word;
    `CHECK("a_ser_oe_pin", 1'h0, chan_a_ser_oe)
    `CHECK("a_rx_oe_pin", 1'h0, chan_a_rx_oe)
    `CHECK("b_ser_oe_pin", 1'h1, chan_b_ser_oe)
    @(posedge mclk);
    chan_a_tx_word <= ~held;
    settle();
    `CHECK("a_ser_frozen", held, chan_a_ser_word)
    @(posedge mclk);
    chan_a_powerdown_n <= 1'h1;
    reg_write({1'h1, REG_CTRL}, 16'hFFFF);
    settle();
    `CHECK("b_ser_oe_reg", 1'h0, chan_b_ser_oe)
    `CHECK("b_rx_oe_reg", 1'h0, chan_b_rx_oe)
    `CHECK("a_ser_oe_back", 1'h1, chan_a_ser_oe)
    check_reg("ctrl_in_pd", {1'h1, REG_CTRL}, CTRL_MASK);
    reg_write({1'h1, REG_CTRL}, 16'h0000);
    settle();
    `CHECK("b_ser_oe_back", 1'h1, chan_b_ser_oe)
    reg_write({1'h0, REG_CTRL}, CTRL_MASK);
    settle();
    `CHECK("a_ser_oe_reg", 1'h0, chan_a_ser_oe)
    `CHECK("a_rx_oe_reg", 1'h0, chan_a_rx_oe)
    reg_write({1'h0, REG_CTRL}, 16'h0000);
    $display("test powerdown done");
  endtask : t_powerdown

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // no wait here is open-ended, but a stuck simulator still ends in the report
  initial begin
    #400000;
    mismatches++;
    final_report();
  end

  initial begin
    repeat (8) @(posedge mclk);
    rstn <= 1'h1;
    repeat (3) @(posedge mclk);
    t_regs();
    t_loss();
    t_scramble();
    t_powerdown();
    final_report();
  end
endmodule : serdes_channel_scramble_los_test
`default_nettype wire
